// ==== src/sspt_timing_gen.sv ====
// What this block does
// - Eight-bit page register picks which register page later accesses reach; resets zero.
// - Mode bit 7 high tristates the line pulse pin; low drives it.
// - Mode bit 6 low: pulse follows external trigger; high: internal period generator.
// - Pulse lasts twice width register plus one i_clk cycles; width resets 0x27.
// - Pixel clock polarity bit 0 rests low when off; 1 rests high.
// - Control bits 7..4 enable, polarity, half rate, run-during-pulse for output a.
// - Control bits 3..0 do the same for pixel clock output b.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "sspt_cfg.svh"

module sspt_timing_gen
   import sspt_pkg::*;
#(
   parameter int ADDR_W = 5,
   parameter int PERIOD_W = 16
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   output logic [7:0] o_page_select,
   // Sensor side
   input wire logic i_external_line_trigger,
   output logic o_line_transfer_pulse,
   output logic o_line_transfer_pulse_oe,
   output logic o_pixel_clock_out_a,
   output logic o_pixel_clock_out_b
);

   // ==========================================================
   // Elaboration checks: the decode and the period compare have fixed widths
   if (ADDR_W != 5) begin : g_bad_addr_w
      $error("ADDR_W must be 5");
   end
   if (PERIOD_W != 16) begin : g_bad_period_w
      $error("PERIOD_W must be 16");
   end

   // ==========================================================
   // Register file
   logic [7:0] page_r;
   logic [7:0] page_nxt;
   logic [7:0] mode_r;
   logic [7:0] mode_nxt;
   logic [7:0] width_r;
   logic [7:0] width_nxt;
   logic [7:0] pixctl_r;
   logic [7:0] pixctl_nxt;
   logic [7:0] per_lo_r;
   logic [7:0] per_lo_nxt;
   logic [7:0] per_hi_r;
   logic [7:0] per_hi_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic on_timing_page;

   // Sequencer state
   sspt_state_t state_r;
   sspt_state_t state_nxt;
   logic [8:0] cnt_r;
   logic [8:0] cnt_nxt;
   logic [PERIOD_W-1:0] per_cnt_r;
   logic [PERIOD_W-1:0] per_cnt_nxt;
   logic trig_d_r;
   logic trig_d_nxt;
   logic pulse_out_r;
   logic pulse_out_nxt;
   logic line_active;
   logic fire;
   logic master;

   sspt_pix_cfg_t cfg_a;
   sspt_pix_cfg_t cfg_b;

   // Only the page register is reachable everywhere; others need page 2
   assign on_timing_page = (page_r == `SSPT_TIMING_PAGE);

   // ==========================================================
   // Register writes and read data, one cycle after the read strobe
   always_comb begin
      page_nxt = page_r;
      mode_nxt = mode_r;
      width_nxt = width_r;
      pixctl_nxt = pixctl_r;
      per_lo_nxt = per_lo_r;
      per_hi_nxt = per_hi_r;
      rdata_nxt = 8'h00;
      if (i_wr) begin
         if (i_addr == `SSPT_OFS_PAGE_SELECT) begin
            page_nxt = i_wdata;
         end else if (on_timing_page && i_addr == `SSPT_OFS_LINE_PULSE_MODE) begin
            mode_nxt = i_wdata;
         end else if (on_timing_page && i_addr == `SSPT_OFS_LINE_PULSE_WIDTH) begin
            width_nxt = i_wdata;
         end else if (on_timing_page && i_addr == `SSPT_OFS_PIX_PAIR_A_CTRL) begin
            pixctl_nxt = i_wdata;
         end else if (on_timing_page && i_addr == `SSPT_OFS_LINE_PERIOD_LO) begin
            per_lo_nxt = i_wdata;
         end else if (on_timing_page && i_addr == `SSPT_OFS_LINE_PERIOD_HI) begin
            per_hi_nxt = i_wdata;
         end
      end
      // Unmapped addresses and foreign pages read as zero
      if (i_rd) begin
         if (i_addr == `SSPT_OFS_PAGE_SELECT) begin
            rdata_nxt = page_r;
         end else if (on_timing_page && i_addr == `SSPT_OFS_LINE_PULSE_MODE) begin
            rdata_nxt = mode_r;
         end else if (on_timing_page && i_addr == `SSPT_OFS_LINE_PULSE_WIDTH) begin
            rdata_nxt = width_r;
         end else if (on_timing_page && i_addr == `SSPT_OFS_PIX_PAIR_A_CTRL) begin
            rdata_nxt = pixctl_r;
         end else if (on_timing_page && i_addr == `SSPT_OFS_LINE_PERIOD_LO) begin
            rdata_nxt = per_lo_r;
         end else if (on_timing_page && i_addr == `SSPT_OFS_LINE_PERIOD_HI) begin
            rdata_nxt = per_hi_r;
         end else if (on_timing_page && i_addr == `SSPT_OFS_STATUS) begin
            rdata_nxt = {5'h00, state_r, line_active};
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         page_r <= `SSPT_RST_PAGE_SELECT;
         mode_r <= `SSPT_RST_LINE_PULSE_MODE;
         width_r <= `SSPT_RST_LINE_PULSE_WIDTH;
         pixctl_r <= `SSPT_RST_PIX_PAIR_A_CTRL;
         per_lo_r <= `SSPT_RST_LINE_PERIOD_LO;
         per_hi_r <= `SSPT_RST_LINE_PERIOD_HI;
         rdata_r <= 8'h00;
      end else begin
         page_r <= page_nxt;
         mode_r <= mode_nxt;
         width_r <= width_nxt;
         pixctl_r <= pixctl_nxt;
         per_lo_r <= per_lo_nxt;
         per_hi_r <= per_hi_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // Line pulse sequencer
   assign master = mode_r[`SSPT_MODE_MASTER_BIT];
   assign line_active = (state_r == SSPT_PULSE);

   // Fire on a trigger rising edge in slave mode, or period wrap in master mode
   always_comb begin
      trig_d_nxt = i_external_line_trigger;
      per_cnt_nxt = per_cnt_r;
      fire = 1'b0;
      if (master) begin
         if (per_cnt_r >= {per_hi_r, per_lo_r}) begin
            per_cnt_nxt = '0;
            fire = 1'b1;
         end else begin
            per_cnt_nxt = per_cnt_r + 1'b1;
         end
      end else begin
         per_cnt_nxt = '0;
         fire = i_external_line_trigger && !trig_d_r;
      end
   end

   // A trigger that lands while a pulse or delay runs is dropped
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         SSPT_IDLE: begin
            if (fire) begin
               if (!master && mode_r[`SSPT_MODE_DELAY_HI:`SSPT_MODE_DELAY_LO] != 4'h0) begin
                  state_nxt = SSPT_DELAY;
                  cnt_nxt = {5'h00, mode_r[`SSPT_MODE_DELAY_HI:`SSPT_MODE_DELAY_LO]} - 9'h001;
               end else begin
                  state_nxt = SSPT_PULSE;
                  cnt_nxt = {width_r, 1'b0};
               end
            end
         end
         SSPT_DELAY: begin
            if (cnt_r == 9'h000) begin
               state_nxt = SSPT_PULSE;
               cnt_nxt = {width_r, 1'b0};
            end else begin
               cnt_nxt = cnt_r - 9'h001;
            end
         end
         SSPT_PULSE: begin
            // Counts 2*width down to zero: 2*width+1 cycles high
            if (cnt_r == 9'h000) begin
               state_nxt = SSPT_IDLE;
            end else begin
               cnt_nxt = cnt_r - 9'h001;
            end
         end
         default: begin
            state_nxt = SSPT_IDLE;
            cnt_nxt = 9'h000;
         end
      endcase
   end

   // Output mode: pass, force low or force high
   always_comb begin
      case (mode_r[`SSPT_MODE_OUT_HI:`SSPT_MODE_OUT_LO])
         2'b10: pulse_out_nxt = 1'b0;
         2'b11: pulse_out_nxt = 1'b1;
         default: pulse_out_nxt = (state_nxt == SSPT_PULSE);
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= SSPT_IDLE;
         cnt_r <= 9'h000;
         per_cnt_r <= '0;
         trig_d_r <= 1'b0;
         pulse_out_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         per_cnt_r <= per_cnt_nxt;
         trig_d_r <= trig_d_nxt;
         pulse_out_r <= pulse_out_nxt;
      end
   end

   // ==========================================================
   // Pixel clock outputs
   assign cfg_a = pixctl_r[`SSPT_PIX_A_LSB+3:`SSPT_PIX_A_LSB];
   assign cfg_b = pixctl_r[`SSPT_PIX_B_LSB+3:`SSPT_PIX_B_LSB];

   sspt_pix_clk u_pix_a (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_cfg(cfg_a),
      .i_line_active(line_active),
      .o_pix(o_pixel_clock_out_a)
   );

   sspt_pix_clk u_pix_b (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_cfg(cfg_b),
      .i_line_active(line_active),
      .o_pix(o_pixel_clock_out_b)
   );

   // ==========================================================
   // Pins and read data
   assign o_line_transfer_pulse = pulse_out_r;
   assign o_line_transfer_pulse_oe = ~mode_r[`SSPT_MODE_TRISTATE_BIT];
   assign o_rdata = rdata_r;
   assign o_page_select = page_r;

endmodule

`default_nettype wire

// ==== shared/sspt_cfg.svh ====
`ifndef SSPT_CFG_SVH
`define SSPT_CFG_SVH

// ==========================================================
// Register map: page select is reachable from every page
`define SSPT_OFS_PAGE_SELECT 5'h1F
`define SSPT_TIMING_PAGE 8'h02
`define SSPT_OFS_LINE_PULSE_MODE 5'h00
`define SSPT_OFS_LINE_PULSE_WIDTH 5'h01
`define SSPT_OFS_PIX_PAIR_A_CTRL 5'h02
`define SSPT_OFS_LINE_PERIOD_LO 5'h08
`define SSPT_OFS_LINE_PERIOD_HI 5'h09
`define SSPT_OFS_STATUS 5'h0A

// ==========================================================
// Reset values
`define SSPT_RST_PAGE_SELECT 8'h00
`define SSPT_RST_LINE_PULSE_MODE 8'h00
`define SSPT_RST_LINE_PULSE_WIDTH 8'h27
`define SSPT_RST_PIX_PAIR_A_CTRL 8'hC8
`define SSPT_RST_LINE_PERIOD_LO 8'hFF
`define SSPT_RST_LINE_PERIOD_HI 8'h03

// ==========================================================
// Line pulse mode fields
`define SSPT_MODE_TRISTATE_BIT 7
`define SSPT_MODE_MASTER_BIT 6
`define SSPT_MODE_OUT_HI 5
`define SSPT_MODE_OUT_LO 4
`define SSPT_MODE_DELAY_HI 3
`define SSPT_MODE_DELAY_LO 0

// ==========================================================
// Pixel clock control fields: output a in the high nibble, b in the low
`define SSPT_PIX_A_LSB 4
`define SSPT_PIX_B_LSB 0
`define SSPT_PIX_EN_OFS 3
`define SSPT_PIX_POL_OFS 2
`define SSPT_PIX_HALF_OFS 1
`define SSPT_PIX_DURING_OFS 0

`endif

// ==== shared/sspt_pkg.sv ====
package sspt_pkg;

   // ==========================================================
   // One pixel clock output's settings
   typedef struct packed {
      logic en;
      logic pol;
      logic half;
      logic during;
   } sspt_pix_cfg_t;

   // ==========================================================
   // Line pulse sequencer states
   typedef enum logic [1:0] {
      SSPT_IDLE  = 2'b00,
      SSPT_DELAY = 2'b01,
      SSPT_PULSE = 2'b10
   } sspt_state_t;

endpackage

// ==== src/sspt_pix_clk.sv ====
`timescale 1ns/1ps
`default_nettype none

module sspt_pix_clk
   import sspt_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Settings and line pulse state
   input wire sspt_pix_cfg_t i_cfg,
   input wire logic i_line_active,
   // Pixel clock pin
   output logic o_pix
);

   logic phase_r;
   logic phase_nxt;
   logic slow_r;
   logic slow_nxt;
   logic pix_r;
   logic pix_nxt;
   logic run;

   // ==========================================================
   // Next state: toggle at full or half rate, rest at polarity when off
   always_comb begin
      run = i_cfg.en && (!i_line_active || i_cfg.during);
      slow_nxt = run ? ~slow_r : 1'b0;
      phase_nxt = phase_r;
      if (!run) begin
         phase_nxt = 1'b0;
      end else if (!i_cfg.half || slow_r) begin
         phase_nxt = ~phase_r; // Half rate only moves every second cycle
      end
      pix_nxt = phase_nxt ^ i_cfg.pol;
   end

   // Registers, so the pin never glitches on a setting change
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         phase_r <= 1'b0;
         slow_r <= 1'b0;
         pix_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         slow_r <= slow_nxt;
         pix_r <= pix_nxt;
      end
   end

   assign o_pix = pix_r;

endmodule

`default_nettype wire

// ==== tb/sspt_timing_gen_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sspt_cfg.svh"
// =====
// Port checker for the timing generator
module sspt_timing_gen_props
   import sspt_pkg::*;
#(
   parameter int ADDR_W = 5,
   parameter int PERIOD_W = 16
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] o_page_select,
   // Sensor side
   input wire logic i_external_line_trigger,
   input wire logic o_line_transfer_pulse,
   input wire logic o_line_transfer_pulse_oe,
   input wire logic o_pixel_clock_out_a,
   input wire logic o_pixel_clock_out_b
);
   // Shadows of the timing page; writes on other pages are refused
   logic [7:0] md_r, wd_r, px_r;
   logic [9:0] run_r;
   wire logic acc = i_wr && o_page_select == `SSPT_TIMING_PAGE;
   wire logic lp = o_line_transfer_pulse;
   wire logic pa = o_pixel_clock_out_a;
   wire logic pb = o_pixel_clock_out_b;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         md_r <= 8'h00;
         wd_r <= 8'h27;
         px_r <= 8'hC8;
         run_r <= 10'h000;
      end else begin
         if (acc && i_addr == `SSPT_OFS_LINE_PULSE_MODE) md_r <= i_wdata;
         if (acc && i_addr == `SSPT_OFS_LINE_PULSE_WIDTH) wd_r <= i_wdata;
         if (acc && i_addr == `SSPT_OFS_PIX_PAIR_A_CTRL) px_r <= i_wdata;
         // Forced levels would fake a long run, so only passed pulses count
         run_r <= (lp && !md_r[5]) ? run_r + 10'h001 : 10'h000;
      end
   end
   // =====
   // Properties
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   AST_PAGE: assert property (
      i_wr && i_addr == 5'h1F |=> o_page_select == $past(i_wdata)) else $error("page lost");
   AST_OE: assert property (o_line_transfer_pulse_oe == !md_r[7])
      else $error("pin enable wrong");
   AST_TRG: assert property (
      $rose(i_external_line_trigger) && md_r[6:5] == 2'b00 && md_r[3:0] == 4'h0 && !lp
      |=> lp) else $error("trigger missed");
   AST_WID: assert property (
      $fell(lp) && !$past(md_r[5]) |-> run_r == {1'b0, wd_r, 1'b1}) else $error("width");
   AST_FRC: assert property (
      md_r[5] && $past(md_r[5:4]) == md_r[5:4] |-> lp == md_r[4]) else $error("forced");
   AST_OFFA: assert property (
      !$past(px_r[7]) |-> pa == $past(px_r[6])) else $error("idle level a");
   // Output a rests at its polarity during a passed line pulse unless told to run
   AST_DURA: assert property (
      $past(lp) && !$past(md_r[5], 2) && $past(px_r[7]) && !$past(px_r[4])
      |-> pa == $past(px_r[6])) else $error("clock a ran during pulse");
   AST_FULLA: assert property (
      px_r[7] && px_r[5:4] == 2'b01 && $past(px_r) == px_r && $past(px_r, 2) == px_r
      |-> pa != $past(pa)) else $error("full rate a stalled");
   AST_HALFB: assert property (
      px_r[3] && px_r[1:0] == 2'b11 && $past(px_r) == px_r && $past(px_r, 2) == px_r
      && $changed(pb) |=> $stable(pb)) else $error("half rate b fast");
   // Main scenarios reached
   cover property ($rose(lp) && md_r[6]);
   cover property (!o_line_transfer_pulse_oe);
   cover property (md_r[5:4] == 2'b11 && lp);
endmodule
bind sspt_timing_gen sspt_timing_gen_props #(.ADDR_W(ADDR_W), .PERIOD_W(PERIOD_W)) chk_u (
   .i_clk(i_clk),
   .i_nrst(i_nrst),
   .i_addr(i_addr),
   .i_wdata(i_wdata),
   .i_wr(i_wr),
   .i_rd(i_rd),
   .o_rdata(o_rdata),
   .o_page_select(o_page_select),
   .i_external_line_trigger(i_external_line_trigger),
   .o_line_transfer_pulse(o_line_transfer_pulse),
   .o_line_transfer_pulse_oe(o_line_transfer_pulse_oe),
   .o_pixel_clock_out_a(o_pixel_clock_out_a),
   .o_pixel_clock_out_b(o_pixel_clock_out_b)
);
`default_nettype wire

// ==== tb/sspt_sensor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====
// Sensor clock inputs: counts pulses, pulse length and clock edges
module sspt_sensor_model (
   // Clock
   input wire logic i_clk,
   // Pins from the generator
   input wire logic i_lp,
   input wire logic i_lp_oe,
   input wire logic i_pa,
   input wire logic i_pb,
   // Observations
   output var int o_n,
   output var int o_wid,
   output var int o_ea,
   output var int o_eb
);
   logic lp_r = 1'b0;
   logic pa_r = 1'b0;
   logic pb_r = 1'b0;
   int run_r = 0;
   // A released pin falls to the sensor's pull-down
   wire logic pin = i_lp_oe ? i_lp : 1'b0;
   // Sampled on the generator clock i_clk, not on the pixel clock pins; int counters start at zero
   always @(posedge i_clk) begin
      lp_r <= pin;
      pa_r <= i_pa;
      pb_r <= i_pb;
      run_r <= pin ? run_r + 1 : 0;
      if (pin && !lp_r) o_n <= o_n + 1;
      if (!pin && lp_r) o_wid <= run_r;
      o_ea <= o_ea + int'(i_pa != pa_r);
      o_eb <= o_eb + int'(i_pb != pb_r);
   end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====
// Self-checking bench for the timing generator
module tb;
   logic i_clk, i_nrst, i_wr, i_rd, trg, lp, oe, pa, pb;
   logic [4:0] i_addr;
   logic [7:0] i_wdata, o_rdata, pg;
   int n_errors, check_count, ns, wd, ea, eb, t, e0, e1;
   sspt_timing_gen dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_page_select(pg),
      .i_external_line_trigger(trg), .o_line_transfer_pulse(lp),
      .o_line_transfer_pulse_oe(oe), .o_pixel_clock_out_a(pa), .o_pixel_clock_out_b(pb));
   sspt_sensor_model sen_u (.i_clk(i_clk), .i_lp(lp), .i_lp_oe(oe), .i_pa(pa), .i_pb(pb),
      .o_n(ns), .o_wid(wd), .o_ea(ea), .o_eb(eb));
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // =====
   // Bus cycles and compare; each bus task starts at a rising edge, ends at a falling one
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge i_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
      @(posedge i_clk) i_wr <= 1'b0;
      @(negedge i_clk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      @(posedge i_clk) {i_addr, i_rd} <= {a, 1'b1};
      @(posedge i_clk) i_rd <= 1'b0;
      @(negedge i_clk) chk(o_rdata, exp);
      // Read data stand for one cycle only
      @(negedge i_clk) chk(o_rdata, 8'h00);
   endtask
   // Trigger high for one cycle; returns just after the edge that takes it
   task automatic fire;
      @(posedge i_clk) trg <= 1'b1;
      @(posedge i_clk) trg <= 1'b0;
      @(negedge i_clk);
   endtask
   // =====
   // Scenarios
   task automatic t_regs;
      rd(5'h1F, 8'h00);
      wr(5'h00, 8'h30);
      wr(5'h1F, 8'h02);
      rd(5'h1F, 8'h02);
      rd(5'h00, 8'h00);
      rd(5'h01, 8'h27);
      rd(5'h02, 8'hC8);
      rd(5'h05, 8'h00);
      wr(5'h00, 8'h80);
      chk(oe, 1'b0);
      wr(5'h00, 8'h00);
      chk(oe, 1'b1);
      $display("registers done");
   endtask
   task automatic t_pulse(input logic [7:0] w, input logic [3:0] d);
      wr(5'h01, w);
      wr(5'h00, {4'h0, d});
      e0 = ns;
      fire();
      for (t = 0; t < 40 && lp !== 1'b1; t++) @(negedge i_clk);
      chk(t, d);
      // A retrigger only lands inside pulses longer than the trigger cycle
      if (w > 8'h02) begin
         fire();
         rd(5'h0A, 8'h05);
      end
      for (t = 0; t < 900 && lp === 1'b1; t++) @(negedge i_clk);
      repeat (2) @(negedge i_clk);
      chk(wd, {w, 1'b1});
      chk(ns - e0, 1);
      $display("pulse done");
   endtask
   // Forced low comes last, so the pin falls from forced high into forced low and ends low
   task automatic t_force;
      logic [1:0] m;
      for (int c = 0; c < 4; c++) begin
         m = c[1:0] ^ (c[1:0] >> 1);
         wr(5'h00, {2'b00, m, 4'h0});
         fire();
         chk(lp, m != 2'b10);
         repeat (4) @(negedge i_clk);
      end
      wr(5'h00, 8'h00);
      $display("force done");
   endtask
   task automatic t_master;
      wr(5'h08, 8'h0A);
      wr(5'h09, 8'h00);
      wr(5'h01, 8'h01);
      wr(5'h00, 8'h40);
      for (t = 0; t < 99 && lp !== 1'b1; t++) @(negedge i_clk);
      for (t = 0; t < 99 && lp !== 1'b0; t++) @(negedge i_clk);
      for (t = 0; t < 99 && lp !== 1'b1; t++) @(negedge i_clk);
      chk(t, 11 - 3);
      wr(5'h00, 8'h00);
      $display("master done");
   endtask
   task automatic t_pix;
      logic [7:0] ctl [6] = '{8'h00, 8'h44, 8'h90, 8'hB0, 8'h09, 8'h0B};
      int xa [6] = '{0, 0, 16, 8, 0, 0};
      int xb [6] = '{0, 0, 0, 0, 16, 8};
      for (int i = 0; i < 6; i++) begin
         wr(5'h02, ctl[i]);
         repeat (2) @(negedge i_clk);
         {e0, e1} = {ea, eb};
         repeat (16) @(negedge i_clk);
         chk(ea - e0, xa[i]);
         chk(eb - e1, xb[i]);
         if (i < 2) chk({pa, pb}, {ctl[i][6], ctl[i][2]});
      end
      $display("pixel clocks done");
   endtask
   // =====
   // Verdict, reached by the sequence or by the watchdog
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #40000;
      n_errors++;
      stop_test();
   end
   initial begin
      {n_errors, check_count} = '0;
      {i_nrst, i_wr, i_rd, trg, i_addr, i_wdata} = '0;
      repeat (10) @(posedge i_clk);
      i_nrst <= 1'b1;
      t_regs();
      t_pulse(8'hFF, 4'hF);
      t_pulse(8'h05, 4'h0);
      t_pulse(8'h00, 4'h3);
      t_force();
      t_master();
      t_pix();
      stop_test();
   end
endmodule
`default_nettype wire
